// File: logic/rnp_pkg.sv
package rnp_pkg;
   // ==========================================================
   // timing figures of the reset pin filter
   localparam int unsigned CLK_PERIOD_PS = 25000;
   localparam int unsigned FILT_MIN_PS = 10000;    // pulses shorter than this are ignored
   localparam int unsigned FILT_SAFE_PS = 100000;  // pulses longer than this always pass
   // least time rounds up; longest-ignored rounds down, floor of one cycle
   localparam int unsigned FILT_PASS_CYC = (FILT_SAFE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FILT_IGN_CYC_RAW = FILT_MIN_PS / CLK_PERIOD_PS;
   localparam int unsigned FILT_IGN_CYC = (FILT_IGN_CYC_RAW < 1) ? 1 : FILT_IGN_CYC_RAW;
   // length of the internal reset sequence in clocks
   localparam int unsigned RST_SEQ_CYC = 16;
   localparam int unsigned SYNC_STAGES = 2;

   // ==========================================================
   // reset cause encoding reported on the cause flags
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_HW_LONG = 2'h1;
   localparam logic [1:0] CAUSE_SW = 2'h2;
   localparam logic [1:0] CAUSE_WDT = 2'h3;

   // sequencer states
   typedef enum logic [1:0]
   {
      RNP_RUN = 2'b00,
      RNP_SEQ = 2'b01,
      RNP_INIT = 2'b10,
      RNP_PDN = 2'b11
   } rnp_state_e;
endpackage : rnp_pkg

// File: logic/rnp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-flop level synchroniser, set to an idle level at reset
module rnp_sync
   import rnp_pkg::*;
#(
   parameter logic IDLE = 1'b1
)
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_q;
   logic sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         meta_q <= IDLE;
         sync_q <= IDLE;
      end
      else
      begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule : rnp_sync
`default_nettype wire

// File: logic/rnp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rnp_ctrl
   import rnp_pkg::*;
#(
   parameter int unsigned SEQ_CYC = RST_SEQ_CYC,
   parameter int unsigned PASS_CYC = FILT_PASS_CYC
)
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic reset_line_in,
   input wire logic nmi_n_in,
   input wire logic sw_reset_in,
   input wire logic wdt_reset_in,
   input wire logic end_of_init_instruction_in,
   input wire logic power_down_instruction_in,
   input wire logic wake_in,
   input wire logic bidir_wr_in,
   input wire logic bidir_wdata_in,
   output logic reset_line_out,
   output logic reset_line_oe_n_out,
   output logic reset_indication_output_n_out,
   output logic core_reset_out,
   output logic nmi_trap_out,
   output logic power_down_out,
   output logic bidir_reset_enable_out,
   output logic [1:0] reset_cause_out
);
   localparam int CW = $clog2(SEQ_CYC + PASS_CYC + 2);

   // ==========================================================
   // input synchronisers
   logic rst_s;
   logic nmi_s;
   rnp_sync #(.IDLE(1'b1)) u_rst_sync (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .d_in(reset_line_in), .q_out(rst_s));
   rnp_sync #(.IDLE(1'b1)) u_nmi_sync (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
      .d_in(nmi_n_in), .q_out(nmi_s));

   // ==========================================================
   // state
   rnp_state_e state_q, state_d;
   logic [CW-1:0] filt_q, filt_d;
   logic [CW-1:0] seq_q, seq_d;
   logic nmi_prev_q;
   logic trap_q;
   logic bidir_q, bidir_d;
   logic [1:0] cause_q, cause_d;
   logic rstind_n_q, line_oe_n_q, core_q, pdn_q;

   // ==========================================================
   // decoding
   wire hw_req = (filt_q >= CW'(PASS_CYC)) && line_oe_n_q;
   wire any_req = hw_req || sw_reset_in || wdt_reset_in;
   wire in_seq = (state_q == RNP_SEQ);
   wire seq_done = in_seq && (seq_q == CW'(SEQ_CYC - 1));
   // own drive must not retrigger, so the filter only counts when not driving
   assign filt_d = (rst_s || !line_oe_n_q) ? '0 :
      ((filt_q >= CW'(PASS_CYC)) ? filt_q : filt_q + CW'(1));
   wire lock = (state_q == RNP_RUN) || (state_q == RNP_PDN);
   wire nmi_fall = nmi_prev_q && !nmi_s;
   wire pdn_ok = power_down_instruction_in && !nmi_s;

   // next-state and cause logic
   always_comb
   begin
      state_d = state_q;
      seq_d = seq_q;
      cause_d = cause_q;
      bidir_d = bidir_q;
      if (bidir_wr_in && !lock && !in_seq)
         bidir_d = bidir_wdata_in;
      case (state_q)
         RNP_SEQ:
         begin
            seq_d = seq_q + CW'(1); // runs the whole length even for a short pulse
            // the enable lasts through the sequence so the line stays driven to its end
            if (seq_done)
            begin
               state_d = (hw_req && !bidir_q) ? RNP_SEQ : RNP_INIT;
               seq_d = '0;
               bidir_d = 1'b0;
            end
         end
         RNP_INIT:
            if (end_of_init_instruction_in)
               state_d = RNP_RUN;
         RNP_RUN:
            if (pdn_ok)
               state_d = RNP_PDN;
         RNP_PDN:
            if (wake_in)
               state_d = RNP_RUN;
         default:
            state_d = RNP_SEQ;
      endcase
      if (any_req && !in_seq)
      begin
         state_d = RNP_SEQ;
         seq_d = '0;
         if (bidir_q || hw_req)
            cause_d = CAUSE_HW_LONG;
         else if (sw_reset_in)
            cause_d = CAUSE_SW;
         else
            cause_d = CAUSE_WDT;
      end
   end

   // ==========================================================
   // registers; power-on starts an internal sequence
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state_q <= RNP_SEQ;
         seq_q <= '0;
         filt_q <= '0;
         bidir_q <= 1'b0;
         cause_q <= CAUSE_HW_LONG;
         nmi_prev_q <= 1'b1;
         trap_q <= 1'b0;
         rstind_n_q <= 1'b0;
         line_oe_n_q <= 1'b1;
         core_q <= 1'b1;
         pdn_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         seq_q <= seq_d;
         filt_q <= filt_d;
         bidir_q <= bidir_d;
         cause_q <= cause_d;
         nmi_prev_q <= nmi_s;
         trap_q <= nmi_fall && (state_q == RNP_RUN);
         rstind_n_q <= (state_d == RNP_RUN) || (state_d == RNP_PDN);
         line_oe_n_q <= !(bidir_q && (state_d == RNP_SEQ));
         core_q <= (state_d == RNP_SEQ);
         pdn_q <= (state_d == RNP_PDN);
      end
   end

   // ==========================================================
   // outputs; line driven low with oe low meaning drive
   assign reset_line_out = 1'b0;
   assign reset_line_oe_n_out = line_oe_n_q;
   assign reset_indication_output_n_out = rstind_n_q;
   assign core_reset_out = core_q;
   assign nmi_trap_out = trap_q;
   assign power_down_out = pdn_q;
   assign bidir_reset_enable_out = bidir_q;
   assign reset_cause_out = cause_q;

   // ==========================================================
   // checks
   // helper for the length check: clocks spent in the current sequence;
   // it saturates so a restarted sequence cannot wrap round and look short
   logic [CW-1:0] seq_len_q;
   always_ff @(posedge sys_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         seq_len_q <= '0;
      else if (!in_seq)
         seq_len_q <= '0;
      else if (seq_len_q != '1)
         seq_len_q <= seq_len_q + CW'(1);
   end

   ind_low_seq_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      in_seq |=> !reset_indication_output_n_out) else $error("indication high in reset");
   ind_until_init_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_q == RNP_INIT && !end_of_init_instruction_in && !any_req)
      |=> !reset_indication_output_n_out) else $error("indication released early");
   ind_release_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_q == RNP_INIT && end_of_init_instruction_in && !any_req)
      |=> reset_indication_output_n_out) else $error("indication not released");
   nmi_trap_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (nmi_fall && state_q == RNP_RUN) |=> nmi_trap_out) else $error("trap missed");
   trap_single_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      nmi_trap_out |=> !nmi_trap_out) else $error("trap longer than one clock");
   pdn_nmi_high_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_q == RNP_RUN && power_down_instruction_in && nmi_s && !any_req)
      |=> !power_down_out) else $error("power-down with nmi high");
   pdn_enter_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (state_q == RNP_RUN && pdn_ok && !any_req) |=> power_down_out)
      else $error("power-down not entered");
   bidir_lock_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      lock |=> $stable(bidir_reset_enable_out)) else $error("bidir changed");
   bidir_drive_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (bidir_q && in_seq && !seq_done) |=> !reset_line_oe_n_out) else $error("line not driven");
   line_release_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      !bidir_q |=> reset_line_oe_n_out) else $error("line driven without bidir");
   cause_long_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (bidir_q && any_req && !in_seq) |=> reset_cause_out == CAUSE_HW_LONG)
      else $error("cause not long hw");
   hw_reset_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      (hw_req && !in_seq) |=> core_reset_out) else $error("reset not entered");
   stretch_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      ($rose(in_seq)) |-> in_seq [*8]) else $error("sequence cut short");
   seq_len_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
      $fell(core_reset_out) |-> seq_len_q >= CW'(SEQ_CYC)) else $error("sequence too short");

   // main scenarios
   cv_hw_c: cover property (@(posedge sys_clk_in) hw_req && state_q == RNP_RUN);
   cv_pdn_c: cover property (@(posedge sys_clk_in) pdn_ok && state_q == RNP_RUN);
   cv_trap_c: cover property (@(posedge sys_clk_in) nmi_trap_out);
   cv_bidir_c: cover property (@(posedge sys_clk_in) bidir_q && in_seq);
   cv_wdt_c: cover property (@(posedge sys_clk_in) wdt_reset_in && !in_seq);
endmodule : rnp_ctrl
`default_nettype wire

// File: tb/rnp_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external reset source (open drain) and interrupt source
module rnp_supervisor
(
   input wire logic pull_low_in,
   input wire logic nmi_level_in,
   input wire logic dut_oe_n_in,
   output logic reset_line_out,
   output logic nmi_n_out
);
   // wired-and with pull-up: either party pulling low wins, released line floats high
   assign reset_line_out = (pull_low_in || !dut_oe_n_in) ? 1'b0 : 1'b1;
   // interrupt source holds its level; low lets the power-down instruction take effect
   assign nmi_n_out = nmi_level_in;
endmodule : rnp_supervisor
`default_nettype wire

// File: tb/reset_nmi_powerdown_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module reset_nmi_powerdown_ctrl_tb_top;
   import rnp_pkg::*;
   typedef struct {logic nmi; logic trap; logic pdn;} rnp_row_s;
   logic sys_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic pull_low = 1'b0;
   logic nmi_lvl = 1'b1;
   logic sw = 1'b0;
   logic wdt = 1'b0;
   logic eoi = 1'b0;
   logic pdi = 1'b0;
   logic wake = 1'b0;
   logic bwr = 1'b0;
   logic bwd = 1'b0;
   wire logic line, nmi_n, line_o, oe_n, ind_n, core_rst, trap, pdn, bidir;
   wire logic [1:0] cause;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n = 0;
   logic seen;
   rnp_row_s rows [2] = '{'{1'b0, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b0}};

   always #12.5 sys_clk_in = ~sys_clk_in;

   rnp_supervisor sup (.pull_low_in(pull_low), .nmi_level_in(nmi_lvl), .dut_oe_n_in(oe_n),
      .reset_line_out(line), .nmi_n_out(nmi_n));
   rnp_ctrl DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reset_line_in(line),
      .nmi_n_in(nmi_n), .sw_reset_in(sw), .wdt_reset_in(wdt),
      .end_of_init_instruction_in(eoi), .power_down_instruction_in(pdi), .wake_in(wake),
      .bidir_wr_in(bwr), .bidir_wdata_in(bwd), .reset_line_out(line_o),
      .reset_line_oe_n_out(oe_n), .reset_indication_output_n_out(ind_n),
      .core_reset_out(core_rst), .nmi_trap_out(trap), .power_down_out(pdn),
      .bidir_reset_enable_out(bidir), .reset_cause_out(cause));

   // ==========================================================
   // shared tasks
   task automatic check(input string name, input logic [1:0] seen_v, input logic [1:0] exp);
      cmp_count++;
      if (seen_v !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen_v);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : step

   // bounded wait; the full sequence is 16 clocks plus filter latency
   task automatic wait_core(input logic v);
      int i;
      i = 0;
      while (core_rst !== v && i < 60)
      begin
         step(1);
         i++;
      end
      check("core_reset_wait", {1'b0, core_rst}, {1'b0, v});
   endtask : wait_core

   task automatic pulse_eoi();
      eoi = 1'b1;
      step(1);
      eoi = 1'b0;
      step(2);
   endtask : pulse_eoi

   task automatic write_bidir(input logic v);
      bwr = 1'b1;
      bwd = v;
      step(1);
      bwr = 1'b0;
      step(2);
   endtask : write_bidir

   task automatic test_done();
      if (err_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // ceiling well above the fewer than two hundred clocks the sequence needs
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         test_done();
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      step(2);
      resetn_in = 1'b1;
      step(1);
      check("ind_during_seq", {1'b0, ind_n}, 2'h0);
      wait_core(1'b0);
      check("ind_before_init", {1'b0, ind_n}, 2'h0);
      pulse_eoi();
      check("ind_after_init", {1'b0, ind_n}, 2'h1);
      // table rows: trap on falling edge, power-down gated by level
      foreach (rows[r])
      begin
         seen = 1'b0;
         nmi_lvl = rows[r].nmi;
         repeat (6)
         begin
            step(1);
            seen = seen | (trap === 1'b1);
         end
         check("nmi_trap", {1'b0, seen}, {1'b0, rows[r].trap});
         pdi = 1'b1;
         step(1);
         pdi = 1'b0;
         step(2);
         check("power_down", {1'b0, pdn}, {1'b0, rows[r].pdn});
         wake = 1'b1;
         step(1);
         wake = 1'b0;
         nmi_lvl = 1'b1;
         step(4);
      end
      // short glitch below the pass count is filtered out
      pull_low = 1'b1;
      step(2);
      pull_low = 1'b0;
      step(10);
      check("glitch_ignored", {1'b0, core_rst}, 2'h0);
      // 100 ns plus two clocks is six clocks here
      pull_low = 1'b1;
      step(6);
      pull_low = 1'b0;
      wait_core(1'b1);
      check("ind_hw_reset", {1'b0, ind_n}, 2'h0);
      check("cause_hw", cause, CAUSE_HW_LONG);
      check("line_free", {1'b0, oe_n}, 2'h1);
      wait_core(1'b0);
      write_bidir(1'b1);
      check("bidir_set", {1'b0, bidir}, 2'h1);
      pulse_eoi();
      write_bidir(1'b0);
      check("bidir_locked", {1'b0, bidir}, 2'h1);
      // software reset with bidirectional mode on drives the line itself
      sw = 1'b1;
      step(1);
      sw = 1'b0;
      wait_core(1'b1);
      step(1);
      check("line_driven", {1'b0, oe_n}, 2'h0);
      check("line_level", {1'b0, line_o}, 2'h0);
      check("cause_long_hw", cause, CAUSE_HW_LONG);
      // count the sequence clocks: a one-clock request still gets the full length
      n = 1;
      while (core_rst === 1'b1 && n < 60)
      begin
         step(1);
         n++;
      end
      check("seq_length", {1'b0, n == RST_SEQ_CYC}, 2'h1);
      wait_core(1'b0);
      check("bidir_cleared", {1'b0, bidir}, 2'h0);
      // watchdog and software resets without bidirectional mode
      wdt = 1'b1;
      step(1);
      wdt = 1'b0;
      check("cause_wdt", cause, CAUSE_WDT);
      check("ind_wdt", {1'b0, ind_n}, 2'h0);
      check("line_free_wdt", {1'b0, oe_n}, 2'h1);
      wait_core(1'b0);
      sw = 1'b1;
      step(1);
      sw = 1'b0;
      check("cause_sw", cause, CAUSE_SW);
      check("core_sw", {1'b0, core_rst}, 2'h1);
      wait_core(1'b0);
      // mid-run power-on reset clears the enable and restarts the sequence
      write_bidir(1'b1);
      resetn_in = 1'b0;
      step(1);
      check("rst_core", {1'b0, core_rst}, 2'h1);
      check("rst_ind", {1'b0, ind_n}, 2'h0);
      check("rst_bidir", {1'b0, bidir}, 2'h0);
      check("rst_line", {1'b0, oe_n}, 2'h1);
      check("rst_cause", cause, CAUSE_HW_LONG);
      check("rst_trap", {1'b0, trap}, 2'h0);
      resetn_in = 1'b1;
      wait_core(1'b0);
      check("rst_pdn", {1'b0, pdn}, 2'h0);
      check("rst_ind_init", {1'b0, ind_n}, 2'h0);
      test_done();
   end
endmodule : reset_nmi_powerdown_ctrl_tb_top
`default_nettype wire
